// ===== pkg/psm_pkg.sv
// Register map, field layout and mode codes for the PHY status/crossover/cable bank
package psm_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0]  IDX_BASIC_CTRL   = 8'h00;
    localparam logic [7:0]  IDX_SYM_ERR      = 8'h1A;
    localparam logic [7:0]  IDX_XOVER_CTRL   = 8'h1B;
    localparam logic [7:0]  IDX_CABLE_LEN    = 8'h1C;
    localparam logic [7:0]  IDX_RESET_CTRL   = 8'h40;
    localparam int          IDX_LSB          = 2;
    localparam int          IDX_MSB          = 9;

    // Basic control and reset control fields
    localparam int          SOFT_RESET_BIT   = 15;
    localparam int          PHY_RESET_BIT    = 1;
    localparam logic        SOFT_RESET_RST   = 1'b0;

    // Crossover / polarity register fields
    localparam int          XO_SRC_BIT       = 15;
    localparam int          XO_EN_BIT        = 14;
    localparam int          XO_STATE_BIT     = 13;
    localparam int          HB_OFF_BIT       = 11;
    localparam int          RX_POL_BIT       = 4;
    localparam logic        XO_SRC_RST       = 1'b0;
    localparam logic        XO_EN_RST        = 1'b0;
    localparam logic        XO_STATE_RST     = 1'b0;
    localparam logic        HB_OFF_RST       = 1'b0;
    localparam logic        RX_POL_RST       = 1'b0;

    // Cable length register fields
    localparam int          CBL_LSB          = 12;
    localparam int          CBL_MSB          = 15;
    localparam int          CBL_RSV_MSB      = 11;
    localparam logic [3:0]  CBL_LEN_RST      = 4'h0;
    localparam logic [11:0] CBL_RSV_RST      = 12'h400;

    // Symbol error counter
    localparam int          SYM_CNT_W        = 16;
    localparam logic [15:0] SYM_CNT_RST      = 16'h0000;

    typedef enum logic [1:0] {
        PSM_XO_AUTO     = 2'b00,
        PSM_XO_STRAIGHT = 2'b01,
        PSM_XO_CROSS    = 2'b10
    } psm_xover_t;
endpackage

// ===== pkg/psm_sym_if.sv
// Carrier between the register bank and the symbol error counter
`timescale 1ns/1ps
interface psm_sym_if #(
    parameter int CNT_W = 16
);
    logic             in_pkt;
    logic             sym_err;
    logic             ten_mode;
    logic [CNT_W-1:0] count;

    modport cnt (
        input  in_pkt,
        input  sym_err,
        input  ten_mode,
        output count
    );
    modport src (
        output in_pkt,
        output sym_err,
        output ten_mode,
        input  count
    );
endinterface

// ===== verilog/psm_sym_counter.sv
// Symbol error counter: one count per packet, wraps, idle in 10BASE-T
`timescale 1ns/1ps
module psm_sym_counter #(
    parameter int CNT_W = 16
) (
    input  wire logic pclk,
    input  wire logic presetn,
    psm_sym_if.cnt    bus
);
    logic [CNT_W-1:0] cnt_r;
    logic             seen_r;

    initial begin
        if (CNT_W < 1) begin
            $error("CNT_W must be at least 1");
        end
    end

    assign bus.count = cnt_r;

    // Idle errors outside a packet count each time; inside, only the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= CNT_W'(psm_pkg::SYM_CNT_RST);
        end else if (bus.sym_err && !bus.ten_mode && !(bus.in_pkt && seen_r)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_r <= 1'b0;
        end else if (!bus.in_pkt) begin
            seen_r <= 1'b0;
        end else if (bus.sym_err) begin
            seen_r <= 1'b1;
        end
    end
endmodule

// ===== verilog/psm_xover_dec.sv
// Decodes crossover control bits into the active crossover mode
`timescale 1ns/1ps
module psm_xover_dec (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              src_sel,
    input  wire logic              man_en,
    input  wire logic              man_state,
    output psm_pkg::psm_xover_t    mode
);
    psm_pkg::psm_xover_t mode_r;
    psm_pkg::psm_xover_t mode_nxt;

    assign mode = mode_r;

    always_comb begin
        mode_nxt = psm_pkg::PSM_XO_AUTO;
        if (src_sel) begin
            case ({man_en, man_state})
                2'b00:   mode_nxt = psm_pkg::PSM_XO_STRAIGHT;
                2'b01:   mode_nxt = psm_pkg::PSM_XO_CROSS;
                2'b10:   mode_nxt = psm_pkg::PSM_XO_AUTO;
                // Reserved pair falls back to automatic, the safest link choice
                default: mode_nxt = psm_pkg::PSM_XO_AUTO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= psm_pkg::PSM_XO_AUTO;
        end else begin
            mode_r <= mode_nxt;
        end
    end
endmodule

// ===== verilog/psm_phy_regs.sv
// APB register bank: symbol errors, crossover control, polarity, cable length
//
// Summary of operation
// - Count invalid received code symbols, idle symbols included.
// - Add at most one count per received packet.
// - Counter wraps to zero past its maximum.
// - Reads leave the count alone; only reset clears it, to zero.
// - No counting while the port runs 10BASE-T.
// - Source select 0 means automatic crossover; 1 uses manual bits.
// - Manual pair 00 straight, 01 crossover, 10 automatic.
// - Heartbeat disable defaults to 0; writing 1 suppresses heartbeat test.
// - Read-only bit 4 shows 10BASE-T receive polarity, 1 reversed.
// - PHY reset restores crossover and heartbeat bits, only with soft reset set.
// - Bits 15:12 hold read-only cable length for fault-free 100BASE-TX, reset 0.
// - No cable length estimate on 10BASE-T links.
`timescale 1ns/1ps
module psm_phy_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_in_packet,
    input  wire logic        rx_symbol_invalid,
    input  wire logic        link_is_10base_t,
    input  wire logic        rx_polarity_reversed,
    input  wire logic [3:0]  cable_length_estimate,
    input  wire logic        cable_fault,
    output logic      [1:0]  crossover_mode,
    output logic             heartbeat_test_disable
);
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] rdata_nxt;
    logic        hit_nxt;

    logic        soft_reset_r;
    logic        src_sel_r;
    logic        man_en_r;
    logic        man_state_r;
    logic        hb_off_r;
    logic        rx_pol_r;
    logic [3:0]  cbl_len_r;
    logic [11:0] cbl_rsv_r;

    logic [7:0]  idx;
    logic        upper_zero;
    logic        aligned;
    logic        wr_en;
    logic        wr_lo;
    logic        wr_hi;
    logic        phy_reset;
    logic [15:0] xo_word;

    psm_pkg::psm_xover_t xo_mode;

    psm_sym_if #(.CNT_W(psm_pkg::SYM_CNT_W)) sym_bus ();

    initial begin
        if (ADDR_W < psm_pkg::IDX_MSB + 1) begin
            $error("ADDR_W too small for the register map");
        end
    end

    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign heartbeat_test_disable = hb_off_r;
    assign crossover_mode         = xo_mode;

    // Address decode: word aligned, nothing above the index field
    assign idx        = paddr[psm_pkg::IDX_MSB:psm_pkg::IDX_LSB];
    assign aligned    = (paddr[1:0] == 2'b00);
    assign upper_zero = (paddr >> (psm_pkg::IDX_MSB + 1)) == '0;

    // Write lands only at the edge the master sees pready high
    assign wr_en = psel && penable && pready_r && pwrite && hit_nxt;
    assign wr_lo = wr_en && pstrb[0];
    assign wr_hi = wr_en && pstrb[1];

    // PHY reset takes effect only while the soft reset bit is armed
    assign phy_reset = wr_lo && (idx == psm_pkg::IDX_RESET_CTRL)
                       && pwdata[psm_pkg::PHY_RESET_BIT] && soft_reset_r;

    always_comb begin
        hit_nxt = 1'b0;
        if (aligned && upper_zero) begin
            case (idx)
                psm_pkg::IDX_BASIC_CTRL: hit_nxt = 1'b1;
                psm_pkg::IDX_SYM_ERR:    hit_nxt = 1'b1;
                psm_pkg::IDX_XOVER_CTRL: hit_nxt = 1'b1;
                psm_pkg::IDX_CABLE_LEN:  hit_nxt = 1'b1;
                psm_pkg::IDX_RESET_CTRL: hit_nxt = 1'b1;
                default:                 hit_nxt = 1'b0;
            endcase
        end
    end

    always_comb begin
        xo_word                         = 16'h0000;
        xo_word[psm_pkg::XO_SRC_BIT]    = src_sel_r;
        xo_word[psm_pkg::XO_EN_BIT]     = man_en_r;
        xo_word[psm_pkg::XO_STATE_BIT]  = man_state_r;
        xo_word[psm_pkg::HB_OFF_BIT]    = hb_off_r;
        xo_word[psm_pkg::RX_POL_BIT]    = rx_pol_r;
    end

    // Read mux; unmapped addresses return zero with an error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_nxt) begin
            case (idx)
                psm_pkg::IDX_BASIC_CTRL:
                    rdata_nxt[psm_pkg::SOFT_RESET_BIT] = soft_reset_r;
                psm_pkg::IDX_SYM_ERR:
                    rdata_nxt[15:0] = sym_bus.count;
                psm_pkg::IDX_XOVER_CTRL:
                    rdata_nxt[15:0] = xo_word;
                psm_pkg::IDX_CABLE_LEN:
                    rdata_nxt[15:0] = {cbl_len_r, cbl_rsv_r};
                default:
                    rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // One wait-free access phase: answer prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr_r <= !hit_nxt;
        end else if (!psel) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_r <= psm_pkg::SOFT_RESET_RST;
        end else if (wr_hi && idx == psm_pkg::IDX_BASIC_CTRL) begin
            soft_reset_r <= pwdata[psm_pkg::SOFT_RESET_BIT];
        end
    end

    // Crossover and heartbeat controls; PHY reset beats a concurrent write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_r   <= psm_pkg::XO_SRC_RST;
            man_en_r    <= psm_pkg::XO_EN_RST;
            man_state_r <= psm_pkg::XO_STATE_RST;
        end else if (phy_reset) begin
            src_sel_r   <= psm_pkg::XO_SRC_RST;
            man_en_r    <= psm_pkg::XO_EN_RST;
            man_state_r <= psm_pkg::XO_STATE_RST;
        end else if (wr_hi && idx == psm_pkg::IDX_XOVER_CTRL) begin
            src_sel_r   <= pwdata[psm_pkg::XO_SRC_BIT];
            man_en_r    <= pwdata[psm_pkg::XO_EN_BIT];
            man_state_r <= pwdata[psm_pkg::XO_STATE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_off_r <= psm_pkg::HB_OFF_RST;
        end else if (phy_reset) begin
            hb_off_r <= psm_pkg::HB_OFF_RST;
        end else if (wr_hi && idx == psm_pkg::IDX_XOVER_CTRL) begin
            hb_off_r <= pwdata[psm_pkg::HB_OFF_BIT];
        end
    end

    // Polarity is only meaningful in 10BASE-T; shown as the receiver reports it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pol_r <= psm_pkg::RX_POL_RST;
        end else begin
            rx_pol_r <= rx_polarity_reversed;
        end
    end

    // Estimate tracks only fault-free 100BASE-TX; cleared in 10BASE-T
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbl_len_r <= psm_pkg::CBL_LEN_RST;
        end else if (link_is_10base_t) begin
            cbl_len_r <= psm_pkg::CBL_LEN_RST;
        end else if (!cable_fault) begin
            cbl_len_r <= cable_length_estimate;
        end
    end

    // Reserved cable bits are plain storage; pattern is software's duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbl_rsv_r <= psm_pkg::CBL_RSV_RST;
        end else if (wr_en && idx == psm_pkg::IDX_CABLE_LEN) begin
            if (pstrb[0]) begin
                cbl_rsv_r[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                cbl_rsv_r[psm_pkg::CBL_RSV_MSB:8] <= pwdata[psm_pkg::CBL_RSV_MSB:8];
            end
        end
    end

    assign sym_bus.in_pkt   = rx_in_packet;
    assign sym_bus.sym_err  = rx_symbol_invalid;
    assign sym_bus.ten_mode = link_is_10base_t;

    psm_sym_counter #(
        .CNT_W (psm_pkg::SYM_CNT_W)
    ) u_sym_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (sym_bus)
    );

    psm_xover_dec u_xover_dec (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_sel   (src_sel_r),
        .man_en    (man_en_r),
        .man_state (man_state_r),
        .mode      (xo_mode)
    );
endmodule

// ===== sim/psm_phy_regs_chk.sv
// Concurrent checks on the ports of the PHY register bank
`timescale 1ns/1ps
module psm_phy_regs_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              rx_polarity_reversed,
    input wire logic              link_is_10base_t,
    input wire logic [1:0]        crossover_mode,
    input wire logic              heartbeat_test_disable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    logic acc;
    logic hb_v;
    assign mapped = paddr inside {12'h000, 12'h068, 12'h06C, 12'h070, 12'h100};
    assign acc = psel && penable && pready;
    function automatic logic [1:0] xo_dec(input logic [2:0] c);
        if (!c[2]) return 2'h0;
        return (c[1:0] == 2'h0) ? 2'h1 : ((c[1:0] == 2'h1) ? 2'h2 : 2'h0);
    endfunction
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_xo_wr;
        acc && pwrite && paddr == 12'h06C && pstrb[1];
    endsequence
    sequence s_rd(a);
        acc && !pwrite && paddr == a;
    endsequence
    chk_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    chk_map_err: assert property (s_setup |=> pslverr == !$past(mapped))
        else $error("error flag wrong for address");
    chk_mode_decode: assert property (
        s_xo_wr |-> ##2 crossover_mode == xo_dec($past(pwdata[15:13], 2)))
        else $error("crossover mode decode wrong");
    chk_hb_follow: assert property (
        (s_xo_wr, hb_v = pwdata[11]) |-> ##2 heartbeat_test_disable == hb_v)
        else $error("heartbeat disable not written");
    chk_xo_rsvd: assert property (s_rd(12'h06C) |->
        (prdata[15:0] & 16'h17EF) == 16'h0 && prdata[4] == $past(rx_polarity_reversed, 2))
        else $error("crossover read bits wrong");
    chk_len_ten: assert property (s_rd(12'h070) ##0 $past(link_is_10base_t, 1)
        ##0 $past(link_is_10base_t, 2) |-> prdata[15:12] == 4'h0)
        else $error("length shown in 10BASE-T");
    chk_rd_upper: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
endmodule

bind psm_phy_regs psm_phy_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_polarity_reversed(rx_polarity_reversed),
    .link_is_10base_t(link_is_10base_t), .crossover_mode(crossover_mode),
    .heartbeat_test_disable(heartbeat_test_disable));

// ===== sim/psm_link_model.sv
// Link partner stand-in: received symbols, line mode, polarity, cable state
`timescale 1ns/1ps
module psm_link_model (
    input  wire logic pclk,
    output logic       in_pkt,
    output logic       sym_bad,
    output logic       ten,
    output logic       pol,
    output logic [3:0] len,
    output logic       fault
);
    initial begin
        in_pkt = 1'b0;
        sym_bad = 1'b0;
        ten = 1'b0;
        pol = 1'b0;
        len = 4'h0;
        fault = 1'b0;
    end
    // Held high, one bad symbol per cycle
    task automatic burst(input int n);
        @(posedge pclk);
        sym_bad <= 1'b1;
        repeat (n - 1) @(posedge pclk);
        @(posedge pclk);
        sym_bad <= 1'b0;
    endtask
    task automatic packet(input int n);
        @(posedge pclk);
        in_pkt <= 1'b1;
        repeat (n) burst(1);
        @(posedge pclk);
        in_pkt <= 1'b0;
    endtask
    task automatic line(input logic t, input logic p, input logic f, input logic [3:0] l);
        @(posedge pclk);
        ten <= t;
        pol <= p;
        fault <= f;
        len <= l;
    endtask
endmodule

// ===== sim/test_psm_phy_regs.sv
// Self-checking bench for the PHY symbol, crossover and cable registers
`timescale 1ns/1ps
module test_psm_phy_regs;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'hF8E08197;
    logic [3:0]  pstrb = 4'h0, len;
    logic        pready, pslverr, in_pkt, sym_bad, ten, pol, fault, hb;
    logic [1:0]  xmode;
    logic [15:0] e;
    logic [32:0] expq[$];
    int          error_cnt = 0, check_count = 0;
    logic [2:0]  ctl_tab[4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    logic [1:0]  mode_tab[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    always #10 pclk = ~pclk;
    psm_phy_regs u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in_packet(in_pkt),
        .rx_symbol_invalid(sym_bad), .link_is_10base_t(ten), .rx_polarity_reversed(pol),
        .cable_length_estimate(len), .cable_fault(fault), .crossover_mode(xmode),
        .heartbeat_test_disable(hb));
    psm_link_model u_link (.pclk(pclk), .in_pkt(in_pkt), .sym_bad(sym_bad), .ten(ten),
        .pol(pol), .len(len), .fault(fault));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Master samples pready at the rising edge and releases at that same edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        expq.push_back(x);
        apb(1'b0, a, 16'h0, 4'h0);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) check(33'h0, 33'h1FFFFFFFF);
            else check({pslverr, prdata}, expq.pop_front());
        end
    end
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h068, 33'h0);
        rd(12'h06C, 33'h0);
        rd(12'h070, 33'h400);
        rd(12'h074, 33'h100000000);
        rd(12'h069, 33'h100000000);
        lfsr = lfsr_step(lfsr);
        u_link.line(1'b0, lfsr[8], 1'b0, lfsr[3:0]);
        rd(12'h06C, {28'h0, lfsr[8], 4'h0});
        rd(12'h070, {17'h0, lfsr[3:0], 12'h400});
        apb(1'b1, 12'h070, 16'hF400, 4'h3);
        // Faulted estimate differs, so a frozen field is told from a copied one
        u_link.line(1'b0, 1'b1, 1'b1, ~lfsr[3:0]);
        rd(12'h070, {17'h0, lfsr[3:0], 12'h400});
        u_link.packet(3);
        rd(12'h068, 33'h1);
        u_link.burst(2);
        rd(12'h068, 33'h3);
        rd(12'h068, 33'h3);
        u_link.line(1'b1, 1'b1, 1'b0, 4'h5);
        u_link.packet(1);
        u_link.burst(3);
        rd(12'h068, 33'h3);
        rd(12'h070, 33'h400);
        u_link.line(1'b0, 1'b1, 1'b0, 4'h5);
        u_link.burst(65533);
        rd(12'h068, 33'h0);
        u_link.burst(1);
        rd(12'h068, 33'h1);
        // Control pair 11 never written while select is set
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_step(lfsr);
            e = {ctl_tab[i], 1'b0, i[0], 11'h0};
            apb(1'b1, 12'h06C, (lfsr[15:0] & 16'h17EF) | e, 4'h3);
            @(posedge pclk);
            @(negedge pclk);
            check(33'(xmode), 33'(mode_tab[i]));
            check(33'(hb), 33'(i[0]));
            rd(12'h06C, {17'h0, e | 16'h10});
        end
        apb(1'b1, 12'h06C, 16'hA800, 4'h3);
        apb(1'b1, 12'h100, 16'h0002, 4'h1);
        rd(12'h06C, 33'hA810);
        apb(1'b1, 12'h000, 16'h8000, 4'h3);
        apb(1'b1, 12'h100, 16'h0002, 4'h1);
        rd(12'h06C, 33'h10);
        check(33'({xmode, hb}), 33'h0);
        apb(1'b1, 12'h06C, 16'hA800, 4'h1);
        rd(12'h06C, 33'h10);
        repeat (2) @(posedge pclk);
        check(33'(expq.size()), 33'h0);
        complete_run();
    end
endmodule
